// ===== logic/swf_spi_target.v
// SPI target transaction engine with wait-state flow control
`timescale 1ns/1ns
`default_nettype none
`include "swf_regs.vh"

module swf_spi_target #(
  parameter        EVT_W     = 8,
  parameter [31:0] CAP_VALUE = 32'h0000_0015,
  parameter [31:0] ID_VALUE  = 32'h0001_ABCD,  // Arbitrary identity value
  parameter [7:0]  REV_VALUE = 8'h01           // Arbitrary revision value
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             spiSclk,
  input  wire             spiCsN,
  input  wire             spiMosi,
  output reg              spiMisoOut_q,
  output reg              spiMisoOeN_q,
  input  wire             parallelIrqNIn,
  output reg              parallelIrqNOut_q,
  output wire             parallelIrqNOeN,
  input  wire             cmdReadyFlag,
  input  wire             resultAvailableFlag,
  input  wire [6:0]       bufFreeBytes,
  input  wire [EVT_W-1:0] intEvents,
  input  wire [7:0]       dataRdByte,
  output reg              dataRdStrobe_q,
  output reg  [7:0]       dataWrByte_q,
  output reg              dataWrValid_q,
  output wire             digestBegin
);

  localparam [3:0] PH_CMD  = 4'b0001;
  localparam [3:0] PH_ADDR = 4'b0010;
  localparam [3:0] PH_WAIT = 4'b0100;
  localparam [3:0] PH_DATA = 4'b1000;

  // Bytes a write may touch from its start offset
  function [6:0] regSpan;
    input [11:0] off;
    begin
      case ({off[11:2], 2'b00})
        `SWF_OFF_ACCESS, `SWF_OFF_INT_VEC, `SWF_OFF_HASH, `SWF_OFF_RID:
          regSpan = 7'h01 - {6'h00, off[1:0] != 2'b00};
        `SWF_OFF_INT_EN, `SWF_OFF_INT_STS, `SWF_OFF_CAP, `SWF_OFF_STS,
        `SWF_OFF_DEVICE_VENDOR_IDENTITY:
          regSpan = 7'h04 - {5'h00, off[1:0]};
        default:
          regSpan = 7'h00;
      endcase
    end
  endfunction

  reg        sclkS1_q;
  reg        sclkS2_q;
  reg        sclkS3_q;
  reg        csS1_q;
  reg        csS2_q;
  reg        mosiS1_q;
  reg        mosiS2_q;
  reg [3:0]  phase_q;
  reg [2:0]  bitCnt_q;
  reg [1:0]  addrByte_q;
  reg [7:0]  shift_q;
  reg [7:0]  cmd_q;
  reg [23:0] addr_q;
  reg [6:0]  byteIdx_q;
  reg        rdyDrv_q;
  reg        regWrEn_q;
  reg [11:0] regWrAddr_q;
  reg [7:0]  regWrData_q;
  reg        irqPinS1_q;
  reg        irqPinS2_q;

  wire [7:0]  regRdByte;
  wire        sclkRise = sclkS2_q && !sclkS3_q;
  wire        sclkFall = !sclkS2_q && sclkS3_q;
  wire        csActive = !csS2_q;
  wire [7:0]  shiftNext = {shift_q[6:0], mosiS2_q};
  wire        isRead = cmd_q[`SWF_CMD_READ_BIT];
  wire [6:0]  xferSize = {1'b0, cmd_q[`SWF_CMD_SIZE_MSB:0]} + 7'h01;
  wire [9:0]  wordNow = (phase_q == PH_ADDR) ? {addr_q[3:0], shift_q[6:1]} : addr_q[11:2];
  wire        dataWord = ({wordNow, 2'b00} == `SWF_OFF_DATA);
  wire        moreBytes = byteIdx_q < xferSize;
  wire        lastBit = bitCnt_q == `SWF_BITS_PER_BYTE;
  wire [11:0] curOff = dataWord ? addr_q[11:0] : addr_q[11:0] + {5'h00, byteIdx_q};
  wire [7:0]  rdByte = dataWord ? dataRdByte : regRdByte;
  // data reads and writes wait for ready state
  // every other register is ready at once
  wire        readyNow = !dataWord ||
                         (isRead ? resultAvailableFlag
                                 : (cmdReadyFlag && bufFreeBytes >= xferSize));
  // only bytes inside the start register
  wire        wrInReg = byteIdx_q < regSpan(addr_q[11:0]);

  // Level of the shared line, for debug visibility only
  always @(posedge core_clk) begin
    if (rst) begin
      irqPinS1_q <= 1'b1;
      irqPinS2_q <= 1'b1;
    end else begin
      irqPinS1_q <= parallelIrqNIn;
      irqPinS2_q <= irqPinS1_q;
    end
  end

  // Pin synchronisers and clock history
  always @(posedge core_clk) begin
    if (rst) begin
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      csS1_q   <= 1'b1;
      csS2_q   <= 1'b1;
      mosiS1_q <= 1'b0;
      mosiS2_q <= 1'b0;
    end else begin
      sclkS1_q <= spiSclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      csS1_q   <= spiCsN;
      csS2_q   <= csS1_q;
      mosiS1_q <= spiMosi;
      mosiS2_q <= mosiS1_q;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      phase_q           <= PH_CMD;
      bitCnt_q          <= 3'h0;
      addrByte_q        <= 2'h0;
      shift_q           <= 8'h00;
      cmd_q             <= 8'h00;
      addr_q            <= 24'h00_0000;
      byteIdx_q         <= 7'h00;
      rdyDrv_q          <= 1'b0;
      spiMisoOut_q      <= 1'b1;
      spiMisoOeN_q      <= 1'b1;
      parallelIrqNOut_q <= 1'b0;
      regWrEn_q         <= 1'b0;
      regWrAddr_q       <= 12'h000;
      regWrData_q       <= 8'h00;
      dataWrValid_q     <= 1'b0;
      dataWrByte_q      <= 8'h00;
      dataRdStrobe_q    <= 1'b0;
    end else begin
      parallelIrqNOut_q <= 1'b0;
      regWrEn_q         <= 1'b0;
      dataWrValid_q     <= 1'b0;
      dataRdStrobe_q    <= 1'b0;
      if (!csActive) begin
        phase_q      <= PH_CMD;
        bitCnt_q     <= 3'h0;
        addrByte_q   <= 2'h0;
        byteIdx_q    <= 7'h00;
        rdyDrv_q     <= 1'b0;
        spiMisoOut_q <= 1'b1;
        spiMisoOeN_q <= 1'b1;
      end else if (sclkRise) begin
        shift_q  <= shiftNext;
        bitCnt_q <= bitCnt_q + 3'h1;
        case (phase_q)
          PH_CMD: begin
            if (lastBit) begin
              cmd_q   <= shiftNext;
              phase_q <= PH_ADDR;
            end
          end
          PH_ADDR: begin
            if (lastBit) begin
              addr_q     <= {addr_q[15:0], shiftNext};
              addrByte_q <= addrByte_q + 2'h1;
              if (addrByte_q == `SWF_ADDR_BYTES) begin
                byteIdx_q <= 7'h00;
                phase_q   <= rdyDrv_q ? PH_DATA : PH_WAIT;
              end
            end
          end
          PH_WAIT: begin
            if (lastBit && rdyDrv_q) begin
              phase_q <= PH_DATA;
              if (!isRead) begin
                // ready window byte is byte zero
                byteIdx_q   <= 7'h01;
                regWrEn_q   <= !dataWord;
                regWrAddr_q <= curOff;
                regWrData_q <= shiftNext;
                dataWrValid_q <= dataWord;
                dataWrByte_q  <= shiftNext;
              end
            end
          end
          PH_DATA: begin
            // every byte of the length, no stall
            if (lastBit && moreBytes) begin
              byteIdx_q <= byteIdx_q + 7'h01;
              if (isRead) begin
                dataRdStrobe_q <= dataWord;
              end else begin
                regWrEn_q     <= !dataWord && wrInReg;
                regWrAddr_q   <= curOff;
                regWrData_q   <= shiftNext;
                dataWrValid_q <= dataWord;
                dataWrByte_q  <= shiftNext;
              end
            end
          end
          default: begin
            phase_q <= PH_CMD;
          end
        endcase
      end else if (sclkFall) begin
        case (phase_q)
          PH_ADDR: begin
            if (addrByte_q == `SWF_ADDR_BYTES && lastBit) begin
              // wait request at last address bit
              spiMisoOut_q <= readyNow;
              spiMisoOeN_q <= 1'b0;
              rdyDrv_q     <= readyNow;
            end
          end
          PH_WAIT: begin
            // zero for the byte, ready in last bit
            spiMisoOut_q <= lastBit ? readyNow : 1'b0;
            spiMisoOeN_q <= 1'b0;
            rdyDrv_q     <= lastBit ? readyNow : 1'b0;
          end
          PH_DATA: begin
            // first read bit right after address or last wait byte
            // data only, no more wait signalling
            spiMisoOut_q <= (isRead && moreBytes) ? rdByte[~bitCnt_q] : 1'b1;
            spiMisoOeN_q <= 1'b0;
          end
          default: begin
            spiMisoOeN_q <= 1'b1;
          end
        endcase
      end
    end
  end

  swf_reg_file #(
    .EVT_W     (EVT_W),
    .CAP_VALUE (CAP_VALUE),
    .ID_VALUE  (ID_VALUE),
    .REV_VALUE (REV_VALUE)
  ) regFile (
    .core_clk            (core_clk),
    .rst                 (rst),
    .wrEn                (regWrEn_q),
    .wrAddr              (regWrAddr_q),
    .wrData              (regWrData_q),
    .rdAddr              (curOff),
    .rdData              (regRdByte),
    .cmdReadyFlag        (cmdReadyFlag),
    .resultAvailableFlag (resultAvailableFlag),
    .bufFreeBytes        (bufFreeBytes),
    .intEvents           (intEvents),
    .irqOeN_q            (parallelIrqNOeN),
    .digestBegin_q       (digestBegin)
  );

endmodule
`default_nettype wire

// ===== common/swf_regs.vh
// Register map, field positions and reset values of the SPI target
`ifndef SWF_REGS_VH
`define SWF_REGS_VH

`define SWF_OFF_ACCESS      12'h000
`define SWF_OFF_INT_EN      12'h008
`define SWF_OFF_INT_VEC     12'h00C
`define SWF_OFF_INT_STS     12'h010
`define SWF_OFF_CAP         12'h014
`define SWF_OFF_STS         12'h018
`define SWF_OFF_DATA        12'h024
`define SWF_OFF_HASH        12'h028
`define SWF_OFF_DEVICE_VENDOR_IDENTITY     12'hF00
`define SWF_OFF_RID         12'hF04

`define SWF_CMD_READ_BIT    7
`define SWF_CMD_SIZE_MSB    5
`define SWF_INT_GLOBAL_BIT  31
`define SWF_ACC_VALID_BIT   7
`define SWF_ACC_ACTIVE_BIT  5
`define SWF_ACC_REQ_BIT     1
`define SWF_STS_VALID_BIT   7
`define SWF_STS_CMDRDY_BIT  6
`define SWF_STS_AVAIL_BIT   4
`define SWF_STS_BURST_LSB   8

`define SWF_RST_INT_EN      32'h0000_0000
`define SWF_RST_INT_VEC     8'h00
`define SWF_RST_INT_STS     32'h0000_0000
`define SWF_UNMAPPED_WORD   32'hFFFF_FFFF

`define SWF_BITS_PER_BYTE   3'h7
`define SWF_ADDR_BYTES      2'h2

`endif

// ===== logic/swf_reg_file.v
// Register file behind the SPI target engine
`timescale 1ns/1ns
`default_nettype none
`include "swf_regs.vh"

module swf_reg_file #(
  parameter        EVT_W     = 8,
  parameter [31:0] CAP_VALUE = 32'h0000_0015,
  parameter [31:0] ID_VALUE  = 32'h0001_ABCD,  // Arbitrary identity value
  parameter [7:0]  REV_VALUE = 8'h01           // Arbitrary revision value
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             wrEn,
  input  wire [11:0]      wrAddr,
  input  wire [7:0]       wrData,
  input  wire [11:0]      rdAddr,
  output reg  [7:0]       rdData,
  input  wire             cmdReadyFlag,
  input  wire             resultAvailableFlag,
  input  wire [6:0]       bufFreeBytes,
  input  wire [EVT_W-1:0] intEvents,
  output reg              irqOeN_q,
  output reg              digestBegin_q
);

  reg         accessActive_q;
  reg [31:0]  intEnable_q;
  reg [7:0]   intVector_q;
  reg [31:0]  intPending_q;
  reg [31:0]  word;
  reg [31:0]  clrMask;
  wire [11:0] wrWord = {wrAddr[11:2], 2'b00};
  wire [4:0]  wrShift = {wrAddr[1:0], 3'b000};
  wire [31:0] laneMask = 32'h0000_00FF << wrShift;
  wire [31:0] laneData = {24'h00_0000, wrData} << wrShift;

  always @* begin
    case ({rdAddr[11:2], 2'b00})
      `SWF_OFF_ACCESS:  word = {24'h00_0000, 1'b1, 1'b0, accessActive_q, 5'h00};
      `SWF_OFF_INT_EN:  word = intEnable_q;
      `SWF_OFF_INT_VEC: word = {24'h00_0000, intVector_q};
      `SWF_OFF_INT_STS: word = intPending_q;
      `SWF_OFF_CAP:     word = CAP_VALUE;
      `SWF_OFF_STS:     word = {17'h0_0000, bufFreeBytes, 1'b1, cmdReadyFlag, 1'b0,
                                resultAvailableFlag, 4'h0};
      `SWF_OFF_DEVICE_VENDOR_IDENTITY: word = ID_VALUE;
      `SWF_OFF_RID:     word = {24'h00_0000, REV_VALUE};
      default:          word = `SWF_UNMAPPED_WORD;
    endcase
    rdData = word[{rdAddr[1:0], 3'b000} +: 8];
  end

  always @* begin
    clrMask = 32'h0000_0000;
    if (wrEn && wrWord == `SWF_OFF_INT_STS) begin
      clrMask = laneData;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      accessActive_q <= 1'b0;
      intEnable_q    <= `SWF_RST_INT_EN;
      intVector_q    <= `SWF_RST_INT_VEC;
      intPending_q   <= `SWF_RST_INT_STS;
      irqOeN_q       <= 1'b1;
      digestBegin_q  <= 1'b0;
    end else begin
      // New events win over a same-cycle clear
      intPending_q  <= (intPending_q & ~clrMask) | {{(32-EVT_W){1'b0}}, intEvents};
      digestBegin_q <= wrEn && wrWord == `SWF_OFF_HASH && wrAddr[1:0] == 2'b00;
      irqOeN_q <= !(intEnable_q[`SWF_INT_GLOBAL_BIT] &&
                    |(intPending_q & intEnable_q & 32'h7FFF_FFFF));
      if (wrEn) begin
        case (wrWord)
          `SWF_OFF_ACCESS: begin
            if (wrAddr[1:0] == 2'b00 && wrData[`SWF_ACC_ACTIVE_BIT]) begin
              accessActive_q <= 1'b0;
            end else if (wrAddr[1:0] == 2'b00 && wrData[`SWF_ACC_REQ_BIT]) begin
              accessActive_q <= 1'b1;
            end
          end
          `SWF_OFF_INT_EN: begin
            intEnable_q <= (intEnable_q & ~laneMask) | laneData;
          end
          `SWF_OFF_INT_VEC: begin
            if (wrAddr[1:0] == 2'b00) begin
              intVector_q <= wrData;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== test/swf_props.sv
// Checker of the SPI target pin behaviour
`timescale 1ns/1ns
`default_nettype none
module swf_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       spiSclk,
  input wire logic       spiCsN,
  input wire logic       spiMosi,
  input wire logic       spiMisoOut_q,
  input wire logic       spiMisoOeN_q,
  input wire logic       parallelIrqNOut_q,
  input wire logic       parallelIrqNOeN,
  input wire logic       cmdReadyFlag,
  input wire logic       resultAvailableFlag,
  input wire logic [6:0] bufFreeBytes,
  input wire logic       dataWrValid_q
);
  logic        sclkPrev_q;
  logic [5:0]  bitCnt_q;
  logic [31:0] hdr_q;
  wire         rise   = spiSclk && !sclkPrev_q;
  wire         lastA  = rise && !spiCsN && bitCnt_q == 6'h1F;
  wire         isPort = hdr_q[10:1] == 10'h009;
  wire         isRd   = hdr_q[30];
  wire [6:0]   size   = {1'b0, hdr_q[28:23]} + 7'h01;
  wire         canWr  = cmdReadyFlag && bufFreeBytes >= size;
  // Header shift and bit count per frame
  always @(posedge core_clk) begin
    sclkPrev_q <= spiSclk;
    if (rise) begin
      hdr_q <= {hdr_q[30:0], spiMosi};
    end
    if (rst || spiCsN) begin
      bitCnt_q <= 6'h00;
    end else if (rise && bitCnt_q != 6'h3F) begin
      bitCnt_q <= bitCnt_q + 6'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence csIdle;
    spiCsN [*4];
  endsequence
  noWaitCtl_a:
    assert property (lastA && !isPort |-> !spiMisoOeN_q && spiMisoOut_q)
      else $error("wait on control register");
  portWr_a:
    assert property (lastA && isPort && !isRd |-> spiMisoOut_q == canWr)
      else $error("write wait flag wrong");
  portRd_a:
    assert property (lastA && isPort && isRd |-> spiMisoOut_q == resultAvailableFlag)
      else $error("read wait flag wrong");
  misoSteady_a:
    assert property (spiSclk [*3] |-> $stable(spiMisoOut_q))
      else $error("MISO moved with clock high");
  misoRelease_a:
    assert property (csIdle |-> spiMisoOeN_q)
      else $error("MISO driven while deselected");
  irqOpenDrain_a:
    assert property (parallelIrqNOut_q == 1'b0)
      else $error("interrupt pin driven high");
  resetQuiet_a:
    assert property ($fell(rst) |-> parallelIrqNOeN && spiMisoOeN_q)
      else $error("pins not released after reset");
  wrPulse_a:
    assert property (dataWrValid_q |=> !dataWrValid_q [*8])
      else $error("write bytes too close");
endmodule
bind swf_spi_target swf_props swf_props_i (
  .core_clk(core_clk), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
  .spiMisoOut_q(spiMisoOut_q), .spiMisoOeN_q(spiMisoOeN_q),
  .parallelIrqNOut_q(parallelIrqNOut_q), .parallelIrqNOeN(parallelIrqNOeN),
  .cmdReadyFlag(cmdReadyFlag), .resultAvailableFlag(resultAvailableFlag),
  .bufFreeBytes(bufFreeBytes), .dataWrValid_q(dataWrValid_q)
);
`default_nettype wire

// ===== test/swf_host_model.sv
// Host controller model driving the SPI link
`timescale 1ns/1ns
`default_nettype none
module swf_host_model (
  input  wire logic core_clk,
  output var logic  spiSclk,
  output var logic  spiCsN,
  output var logic  spiMosi,
  input  wire logic spiMiso
);
  logic [7:0] buff [0:63];
  int         waits;
  initial begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // drive on fall, sample on rise
  task automatic bitx(input logic b, output logic m);
    spiMosi = b;
    repeat (4) @(negedge core_clk);
    spiSclk = 1'b1;
    m = spiMiso;
    repeat (4) @(negedge core_clk);
    spiSclk = 1'b0;
  endtask
  task automatic xfer(input logic rd, input int n, input logic [11:0] off);
    logic [31:0] hdr;
    logic [7:0]  b;
    logic        m;
    int          i;
    int          k;
    hdr = {rd, 1'b0, 6'(n - 1), 12'h000, off};
    waits = 0;
    spiCsN = 1'b0;
    for (i = 31; i >= 0; i--) bitx(hdr[i], m);
    while (!m && waits < 200) begin
      waits++;
      for (k = 7; k >= 0; k--) bitx(rd ? 1'b0 : buff[0][k], m);
    end
    for (i = (waits > 0 && !rd) ? 1 : 0; i < n; i++) begin
      for (k = 7; k >= 0; k--) begin
        bitx(rd ? 1'b0 : buff[i][k], m);
        b[k] = m;
      end
      if (rd) buff[i] = b;
    end
    spiCsN = 1'b1;
    spiMosi = ~spiMosi;
    repeat (8) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the SPI target engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [31:0] CAP = 32'h0000_0015;
  localparam logic [31:0] ID  = 32'h0000_5A5A;  // Arbitrary identity value
  localparam logic [7:0]  REV = 8'h03;          // Arbitrary revision value
  logic        core_clk, rst, cmdReadyFlag, resultAvailableFlag, dataRdStrobe_q;
  logic        spiSclk, spiCsN, spiMosi, spiMisoOut_q, spiMisoOeN_q, dataWrValid_q;
  logic        parallelIrqNOut_q, parallelIrqNOeN, digestBegin;
  logic [6:0]  bufFreeBytes;
  logic [7:0]  intEvents, dataRdByte, rdFirst, dataWrByte_q, gotWr [$];
  logic [31:0] v, e;
  logic [11:0] offs [0:7] = '{12'h014, 12'hF00, 12'hF04, 12'h008, 12'h00C, 12'h010,
                              12'h000, 12'h030};
  logic [31:0] exps [0:7] = '{CAP, ID, {24'h0, REV}, 32'h0, 32'h0, 32'h0, 32'h80, 32'hFF};
  int          lens [0:7] = '{4, 4, 1, 4, 1, 4, 1, 1};
  wire         spiMiso, irqLine;
  int          mismatches, cmpCount, seed, cyc, digests, rdIdx, i, c, n;
  assign spiMiso = spiMisoOeN_q ? 1'b1 : spiMisoOut_q;
  assign irqLine = parallelIrqNOeN ? 1'b1 : parallelIrqNOut_q;
  swf_spi_target #(.CAP_VALUE(CAP), .ID_VALUE(ID), .REV_VALUE(REV)) swf_spi_target_i (
    .core_clk(core_clk), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMisoOut_q(spiMisoOut_q), .spiMisoOeN_q(spiMisoOeN_q), .parallelIrqNIn(irqLine),
    .parallelIrqNOut_q(parallelIrqNOut_q), .parallelIrqNOeN(parallelIrqNOeN),
    .cmdReadyFlag(cmdReadyFlag), .resultAvailableFlag(resultAvailableFlag),
    .bufFreeBytes(bufFreeBytes), .intEvents(intEvents), .dataRdByte(dataRdByte),
    .dataRdStrobe_q(dataRdStrobe_q), .dataWrByte_q(dataWrByte_q),
    .dataWrValid_q(dataWrValid_q), .digestBegin(digestBegin));
  swf_host_model swf_host_model_i (.core_clk(core_clk), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] off, input int n, input logic [63:0] d);
    int j;
    for (j = 0; j < n; j++) swf_host_model_i.buff[j] = d[8*j +: 8];
    swf_host_model_i.xfer(1'b0, n, off);
  endtask
  task automatic rd(input logic [11:0] off, input int n, output logic [31:0] d);
    int j;
    swf_host_model_i.xfer(1'b1, n, off);
    d = 32'h0;
    for (j = 0; j < n; j++) d[8*j +: 8] = swf_host_model_i.buff[j];
  endtask
  task automatic run(input logic r, input int n);
    fork
      begin
        repeat (400) @(negedge core_clk);
        cmdReadyFlag = 1'b1;
        bufFreeBytes = 7'h40;
        resultAvailableFlag = 1'b1;
      end
      swf_host_model_i.xfer(r, n, 12'h024);
    join
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (dataWrValid_q === 1'b1) gotWr.push_back(dataWrByte_q);
    if (digestBegin === 1'b1) digests++;
    if (cyc == 40000) begin
      mismatches++;
      printVerdict();
    end
  end
  always @(negedge core_clk) begin
    if (dataRdStrobe_q === 1'b1) rdIdx++;
    dataRdByte = 8'hC0 + 8'(rdIdx);
  end
  initial begin
    seed = 51;
    rst = 1'b1;
    {cmdReadyFlag, resultAvailableFlag} = 2'h3;
    bufFreeBytes = 7'h40;
    intEvents = 8'h00;
    dataRdByte = 8'hC0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    for (i = 0; i < 8; i++) begin
      rd(offs[i], lens[i], v);
      chk("fixed reg", exps[i], v);
      chk("fixed waits", 32'h0, 32'(swf_host_model_i.waits));
    end
    repeat (4) begin
      v = $random(seed);
      {cmdReadyFlag, resultAvailableFlag} = v[1:0];
      bufFreeBytes = 7'(v[15:8] % 65);
      e = {17'h0, bufFreeBytes, 1'b1, cmdReadyFlag, 1'b0, resultAvailableFlag, 4'h0};
      rd(12'h018, 2, v);
      chk("status", e, v & 32'h0000_7FD0);
    end
    wr(12'h000, 1, 64'h2);
    rd(12'h000, 1, v);
    chk("access set", 32'hA0, v);
    wr(12'h000, 1, 64'h22);
    rd(12'h000, 1, v);
    chk("access clear", 32'h80, v);
    $display("test registers done");
    wr(12'h008, 4, 64'h8000_00FF);
    @(negedge core_clk);
    intEvents = 8'h04;
    @(negedge core_clk);
    intEvents = 8'h00;
    repeat (4) @(negedge core_clk);
    chk("irq low", 32'h0, 32'(irqLine));
    v = $random(seed);
    e = {24'h0, v[7:0]};
    wr(12'h00C, 8, {56'hFF_FFFF_FFFF_FFFF, v[7:0]});
    rd(12'h00C, 1, v);
    chk("vector", e, v);
    rd(12'h010, 4, v);
    chk("pending kept", 32'h4, v);
    wr(12'h010, 1, 64'h4);
    repeat (4) @(negedge core_clk);
    chk("irq high", 32'h1, 32'(irqLine));
    $display("test interrupt done");
    for (c = 0; c < 3; c++) begin
      cmdReadyFlag = (c != 0);
      bufFreeBytes = (c == 1) ? 7'h04 : ((c == 2) ? 7'h1C : 7'h40);
      n = (c == 2) ? 28 : 8;
      gotWr.delete();
      for (i = 0; i < n; i++) swf_host_model_i.buff[i] = 8'($random(seed));
      run(1'b0, n);
      chk("wr stall", 32'(c != 2), 32'(swf_host_model_i.waits != 0));
      chk("wr count", 32'(n), 32'(gotWr.size()));
      for (i = 0; i < n; i++) begin
        chk("wr byte", 32'(swf_host_model_i.buff[i]), 32'(gotWr[i]));
      end
    end
    for (c = 0; c < 2; c++) begin
      resultAvailableFlag = (c != 0);
      rdFirst = 8'hC0 + 8'(rdIdx);
      run(1'b1, 4);
      chk("rd stall", 32'(c == 0), 32'(swf_host_model_i.waits != 0));
      for (i = 0; i < 4; i++) begin
        chk("rd byte", 32'(rdFirst + 8'(i)), 32'(swf_host_model_i.buff[i]));
      end
    end
    wr(12'h028, 1, 64'h1);
    chk("digest", 32'h1, 32'(digests));
    $display("test data port done");
    printVerdict();
  end
endmodule
`default_nettype wire
